// file: rtl/wdr_defines.svh
// offsets, bit positions, reset values and timing counts of the watchdog
// assumes inclusion by bare name from files that import wdr_pkg
`ifndef WDR_DEFINES_SVH
`define WDR_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define WDR_ADDR_CAUSE 12'h000
`define WDR_ADDR_CTRL 12'h004
`define WDR_ADDR_EVENT 12'h008
`define WDR_ADDR_MASK 12'h00c

// ****************************************
// reset cause flag positions
// ****************************************
`define WDR_BIT_POWERON 0
`define WDR_BIT_PIN 1
`define WDR_BIT_BROWNOUT 2
`define WDR_BIT_WATCHDOG 3
`define WDR_BIT_JTAG 4

// ****************************************
// control field positions and reset values
// ****************************************
`define WDR_BIT_TOFF 4
`define WDR_BIT_EN 3
`define WDR_CTRL_RESET 8'h00
`define WDR_CAUSE_RESET 5'h01
`define WDR_MASK_RESET 3'h0

// ****************************************
// interrupt event positions
// ****************************************
`define WDR_EV_TIMEOUT 0
`define WDR_EV_REFUSED 1
`define WDR_EV_KICK 2

// ****************************************
// timing
// ****************************************
`define WDR_CLK_HZ 25000000
`define WDR_OSC_HZ 1000000
`define WDR_OSC_DIV (`WDR_CLK_HZ / `WDR_OSC_HZ)
`define WDR_TOFF_CYCLES 3'h4
`define WDR_BASE_TICKS 16384

`endif

// file: rtl/wdr_pkg.sv
// types shared by the watchdog and reset cause block
// assumes the constants of wdr_defines.svh
package wdr_pkg;

	typedef struct packed {
		logic jtag;
		logic brownout;
		logic pin;
	} wdr_rst_src_t;

	typedef struct packed {
		logic [2:0] res;
		logic toff;
		logic en;
		logic [2:0] sel;
	} wdr_ctrl_t;

	typedef struct packed {
		wdr_ctrl_t ctrl;
		logic [2:0] toff_cnt;
		logic [21:0] wd_cnt;
		logic wdt_pulse;
		logic [2:0] mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wdr_state_t;

	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} wdr_div_t;

endpackage

// file: rtl/wdr_tick_div.sv
// divider giving a one-cycle enable pulse every DIV clocks
// assumes a free running pclk
`timescale 1ns/100ps
`default_nettype none
module wdr_tick_div
	import wdr_pkg::*;
#(
	parameter int DIV = 25
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// enable pulse
	output logic tick
);

	wdr_div_t s;
	wdr_div_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == 5'(DIV - 1))
		begin
			next_s.cnt = 5'h00;
			next_s.tick = 1'b1;
		end
		else
		begin
			next_s.cnt = s.cnt + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;

endmodule
`default_nettype wire

// file: rtl/wdr_flag.sv
// one sticky flag: hardware set, cleared by writing CLR_VAL to it
// assumes set and write strobe are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module wdr_flag
#(
	parameter logic RESET_VAL = 1'b0,
	parameter logic CLR_VAL = 1'b1
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// set and software clear
	input wire logic set,
	input wire logic wr,
	input wire logic wbit,
	// flag
	output logic q
);

	logic next_q;

	// set wins over a clear in the same cycle
	always_comb
	begin
		next_q = q;
		if (wr && (wbit == CLR_VAL))
			next_q = 1'b0;
		if (set)
			next_q = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= RESET_VAL;
		else
			q <= next_q;
	end

endmodule
`default_nettype wire

// file: rtl/wdr_top.sv
// watchdog timer with reset cause flags behind an APB slave
// assumes presetn is the power-on reset; other reset sources arrive as
// one-cycle pulses synchronous to pclk
//
// How it works
// - jtag reset event sets cause bit 4; power-on or written zero clears
// - watchdog timeout sets cause bit 3; power-on or written zero clears
// - brown-out event sets cause bit 2; power-on or written zero clears
// - pin reset event sets cause bit 1; power-on or written zero clears
// - power-on sets cause bit 0; only a written zero clears it
// - control bits 7:5 always read zero
// - turn-off enable clears itself four clocks after being written one
// - writing enable one starts the watchdog, zero stops it if allowed
// - clearing enable is ignored unless turn-off enable reads one
// - 3-bit select picks timeout 16K doubling up to 2048K ticks
// - counter advances on a 1 MHz tick, apart from the system clock; here the tick is pclk divided by 25
// - kick instruction restarts the count
// - disable or any chip reset restarts the count
// - timeout gives a single-cycle reset pulse
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "wdr_defines.svh"
module wdr_top
	import wdr_pkg::*;
#(
	parameter int WDT_BASE_TICKS = `WDR_BASE_TICKS
)
(
	// clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources and core events
	input wire wdr_rst_src_t rst_src,
	input wire logic watchdog_kick_instruction,
	// results
	output logic watchdog_reset_pulse,
	output logic watchdog_running,
	output logic [4:0] reset_cause,
	output logic irq
);

	// ****************************************
	// state and decode
	// ****************************************
	wdr_state_t s;
	wdr_state_t next_s;
	logic osc_tick;
	logic acc;
	logic wr_cause;
	logic wr_ctrl;
	logic wr_ev;
	logic wr_mask;
	logic any_rst;
	logic restart;
	logic refused;
	logic [21:0] wd_limit;
	logic [4:0] cause_set;
	logic [2:0] ev_set;
	logic [2:0] ev;

	// access phase always completes in its first cycle
	assign acc = psel && penable && s.pready;
	assign wr_cause = acc && pwrite && (paddr == `WDR_ADDR_CAUSE);
	assign wr_ctrl = acc && pwrite && (paddr == `WDR_ADDR_CTRL);
	assign wr_ev = acc && pwrite && (paddr == `WDR_ADDR_EVENT);
	assign wr_mask = acc && pwrite && (paddr == `WDR_ADDR_MASK);
	assign any_rst = rst_src.jtag || rst_src.brownout || rst_src.pin;
	assign restart = watchdog_kick_instruction || !s.ctrl.en || any_rst
		|| s.wdt_pulse;
	assign refused = wr_ctrl && !pwdata[`WDR_BIT_EN] && !s.ctrl.toff
		&& s.ctrl.en;
	assign wd_limit = 22'(WDT_BASE_TICKS) << s.ctrl.sel;

	// ****************************************
	// watchdog oscillator tick
	// ****************************************
	// one clock only, so the oscillator is modelled as an enable pulse
	wdr_tick_div #(
		.DIV(`WDR_OSC_DIV)
	) u_osc (
		.pclk(pclk),
		.presetn(presetn),
		.tick(osc_tick)
	);

	// ****************************************
	// sticky flags
	// ****************************************
	assign cause_set[`WDR_BIT_POWERON] = 1'b0;
	assign cause_set[`WDR_BIT_PIN] = rst_src.pin;
	assign cause_set[`WDR_BIT_BROWNOUT] = rst_src.brownout;
	assign cause_set[`WDR_BIT_WATCHDOG] = s.wdt_pulse;
	assign cause_set[`WDR_BIT_JTAG] = rst_src.jtag;
	assign ev_set[`WDR_EV_TIMEOUT] = s.wdt_pulse;
	assign ev_set[`WDR_EV_REFUSED] = refused;
	assign ev_set[`WDR_EV_KICK] = watchdog_kick_instruction;

	// cause flags only see presetn, so other resets leave them alone
	localparam logic [4:0] CAUSE_RESET = `WDR_CAUSE_RESET;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_cause
			wdr_flag #(
				.RESET_VAL(CAUSE_RESET[gi]),
				.CLR_VAL(1'b0)
			) u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set(cause_set[gi]),
				.wr(wr_cause),
				.wbit(pwdata[gi]),
				.q(reset_cause[gi])
			);
		end
		for (gi = 0; gi < 3; gi++)
		begin : g_event
			wdr_flag #(
				.RESET_VAL(1'b0),
				.CLR_VAL(1'b1)
			) u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set(ev_set[gi]),
				.wr(wr_ev),
				.wbit(pwdata[gi]),
				.q(ev[gi])
			);
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_s = s;
		next_s.wdt_pulse = 1'b0;
		next_s.ctrl.res = 3'h0;
		// turn-off window
		if (s.toff_cnt != 3'h0)
		begin
			next_s.toff_cnt = s.toff_cnt - 3'h1;
			if (s.toff_cnt == 3'h1)
				next_s.ctrl.toff = 1'b0;
		end
		if (wr_ctrl)
		begin
			next_s.ctrl.sel = pwdata[2:0];
			if (pwdata[`WDR_BIT_TOFF])
			begin
				next_s.ctrl.toff = 1'b1;
				next_s.toff_cnt = `WDR_TOFF_CYCLES;
			end
			if (pwdata[`WDR_BIT_EN])
				next_s.ctrl.en = 1'b1;
			else if (s.ctrl.toff)
				next_s.ctrl.en = 1'b0;
		end
		if (wr_mask)
			next_s.mask = pwdata[2:0];
		// watchdog count
		if (restart)
			next_s.wd_cnt = 22'h000000;
		else if (osc_tick)
		begin
			if (s.wd_cnt == wd_limit - 22'h000001)
			begin
				next_s.wd_cnt = 22'h000000;
				next_s.wdt_pulse = 1'b1;
			end
			else
				next_s.wd_cnt = s.wd_cnt + 22'h000001;
		end
		next_s.irq = |(ev & s.mask);
		// apb: answer is prepared in the setup cycle
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && !penable)
		begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h00000000;
			unique case (paddr)
				`WDR_ADDR_CAUSE: next_s.prdata[4:0] = reset_cause;
				`WDR_ADDR_CTRL: next_s.prdata[7:0] = s.ctrl;
				`WDR_ADDR_EVENT: next_s.prdata[2:0] = ev;
				`WDR_ADDR_MASK: next_s.prdata[2:0] = s.mask;
				default: next_s.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.ctrl <= `WDR_CTRL_RESET;
			s.mask <= `WDR_MASK_RESET;
		end
		else
			s <= next_s;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign watchdog_reset_pulse = s.wdt_pulse;
	assign watchdog_running = s.ctrl.en;
	assign irq = s.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence toff_written;
		wr_ctrl && pwdata[`WDR_BIT_TOFF];
	endsequence

	sequence no_toff_rewrite;
		!(wr_ctrl && pwdata[`WDR_BIT_TOFF]);
	endsequence

	a_jtag_flag: assert property (rst_src.jtag |=> reset_cause[4])
		else $error("jtag cause flag not set");
	a_wd_flag: assert property (s.wdt_pulse |=> reset_cause[3])
		else $error("watchdog cause flag not set");
	a_bod_flag: assert property (rst_src.brownout |=> reset_cause[2])
		else $error("brownout cause flag not set");
	a_pin_flag: assert property (rst_src.pin |=> reset_cause[1])
		else $error("pin cause flag not set");
	a_por_hold: assert property (reset_cause[0]
		&& !(wr_cause && !pwdata[0]) |=> reset_cause[0])
		else $error("power-on flag lost without a write");
	a_flag_keep: assert property (any_rst && !wr_cause |=>
		(reset_cause & ~$past(cause_set))
		== ($past(reset_cause) & ~$past(cause_set)))
		else $error("cause flags changed by a reset");
	a_reserved_zero: assert property (pready
		&& paddr == `WDR_ADDR_CTRL |-> prdata[7:5] == 3'h0)
		else $error("reserved control bits read nonzero");
	a_toff_hold: assert property (toff_written |=> s.ctrl.toff[*4])
		else $error("turn-off enable dropped early");
	a_toff_clear: assert property (toff_written ##1 no_toff_rewrite[*4]
		|=> !s.ctrl.toff)
		else $error("turn-off enable not cleared after four clocks");
	a_en_set: assert property (wr_ctrl && pwdata[`WDR_BIT_EN]
		|=> s.ctrl.en)
		else $error("enable write ignored");
	a_en_clear: assert property (wr_ctrl && !pwdata[`WDR_BIT_EN]
		&& s.ctrl.toff |=> !s.ctrl.en)
		else $error("allowed disable ignored");
	a_en_locked: assert property (refused |=> s.ctrl.en)
		else $error("disable accepted without turn-off enable");
	a_timeout_len: assert property (s.wdt_pulse
		|-> $past(s.wd_cnt) == $past(wd_limit) - 22'h000001)
		else $error("timeout at wrong count");
	a_tick_only: assert property (s.wd_cnt != 22'h000000
		&& s.wd_cnt != $past(s.wd_cnt) |-> $past(osc_tick))
		else $error("count moved without an oscillator tick");
	a_kick_restart: assert property (watchdog_kick_instruction
		|=> s.wd_cnt == 22'h000000)
		else $error("kick did not restart count");
	a_idle_restart: assert property (!s.ctrl.en || any_rst
		|=> s.wd_cnt == 22'h000000)
		else $error("count not restarted");
	a_pulse_single: assert property (watchdog_reset_pulse
		|=> !watchdog_reset_pulse)
		else $error("reset pulse longer than one cycle");

	// a written zero clears a flag unless its source fires in that cycle
	a_jtag_clear: assert property (wr_cause
		&& !pwdata[`WDR_BIT_JTAG] && !rst_src.jtag
		|=> !reset_cause[`WDR_BIT_JTAG])
		else $error("jtag cause flag not cleared by write");
	a_wd_clear: assert property (wr_cause
		&& !pwdata[`WDR_BIT_WATCHDOG] && !s.wdt_pulse
		|=> !reset_cause[`WDR_BIT_WATCHDOG])
		else $error("watchdog cause flag not cleared by write");
	a_bod_clear: assert property (wr_cause
		&& !pwdata[`WDR_BIT_BROWNOUT] && !rst_src.brownout
		|=> !reset_cause[`WDR_BIT_BROWNOUT])
		else $error("brownout cause flag not cleared by write");
	a_pin_clear: assert property (wr_cause
		&& !pwdata[`WDR_BIT_PIN] && !rst_src.pin
		|=> !reset_cause[`WDR_BIT_PIN])
		else $error("pin cause flag not cleared by write");
	a_por_clear: assert property (wr_cause
		&& !pwdata[`WDR_BIT_POWERON]
		|=> !reset_cause[`WDR_BIT_POWERON])
		else $error("power-on flag not cleared by write");
	a_refused_event: assert property (refused
		|=> ev[`WDR_EV_REFUSED])
		else $error("refused disable not flagged");
	a_timeout_event: assert property (s.wdt_pulse
		|=> ev[`WDR_EV_TIMEOUT])
		else $error("timeout event not flagged");

endmodule
`default_nettype wire

// file: dv/tb_watchdog_and_reset_cause_flags.sv
// testbench for wdr_top: apb register tasks and directed sequences
// assumes wdr_pkg, wdr_defines.svh and the rtl files compile first
`timescale 1ns/100ps
`default_nettype none
`include "wdr_defines.svh"
module tb_watchdog_and_reset_cause_flags
	import wdr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	wdr_rst_src_t rst_src = '0;
	logic kick = 1'b0;
	logic pulse;
	logic running;
	logic [4:0] reset_cause;
	logic irq;
	int n_errors = 0;
	int checked = 0;
	int c;
	int hits;
	logic [31:0] q;
	logic e;

	always #20 pclk = ~pclk;

	// short base count keeps all eight timeouts inside the run
	wdr_top #(.WDT_BASE_TICKS(4)) dut_u (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rst_src(rst_src),
		.watchdog_kick_instruction(kick),
		.watchdog_reset_pulse(pulse),
		.watchdog_running(running),
		.reset_cause(reset_cause),
		.irq(irq)
	);

	// ****************************************
	// tasks
	// ****************************************
	task automatic summarize();
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, x, g);
		end
	endtask

	// ends with one idle cycle so the next call never retimes psel
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input string s);
		apb(1'b0, a, 32'h0);
		chk(s, x, q);
	endtask

	task automatic src(input wdr_rst_src_t v);
		rst_src <= v;
		@(posedge pclk);
		rst_src <= '0;
		@(posedge pclk);
	endtask

	task automatic wait_pulse();
		c = 0;
		do
		begin
			@(posedge pclk);
			c++;
		end
		while (pulse !== 1'b1 && c < 20000);
		if (c >= 20000)
			n_errors++;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("cause at reset", 32'h1, 32'(reset_cause));
		rd(`WDR_ADDR_CTRL, 32'h0, "ctrl at reset");
		src('{jtag: 1'b1, brownout: 1'b0, pin: 1'b0});
		src('{jtag: 1'b0, brownout: 1'b1, pin: 1'b0});
		src('{jtag: 1'b0, brownout: 1'b0, pin: 1'b1});
		rd(`WDR_ADDR_CAUSE, 32'h17, "cause sources");
		wr(`WDR_ADDR_CAUSE, 32'h1e);
		rd(`WDR_ADDR_CAUSE, 32'h16, "cause clear one");
		wr(`WDR_ADDR_CAUSE, 32'h0);
		wr(`WDR_ADDR_CAUSE, 32'h1f);
		rd(`WDR_ADDR_CAUSE, 32'h0, "cause clear all");
		wr(`WDR_ADDR_CTRL, 32'hf8);
		repeat (5) @(posedge pclk);
		rd(`WDR_ADDR_CTRL, 32'h08, "toff self clear");
		chk("running", 32'h1, 32'(running));
		wr(`WDR_ADDR_CTRL, 32'h0);
		rd(`WDR_ADDR_CTRL, 32'h08, "refused disable");
		wr(`WDR_ADDR_CTRL, 32'h18);
		wr(`WDR_ADDR_CTRL, 32'h0);
		rd(`WDR_ADDR_CTRL, 32'h0, "disabled");
		chk("stopped", 32'h0, 32'(running));
		// interrupt: refused event, masked then unmasked, then cleared
		rd(`WDR_ADDR_EVENT, 32'h2, "event refused");
		wr(`WDR_ADDR_MASK, 32'h0);
		chk("irq masked", 32'h0, 32'(irq));
		// irq is registered from flags and mask, one cycle behind them
		wr(`WDR_ADDR_MASK, 32'h2);
		@(posedge pclk);
		chk("irq raised", 32'h1, 32'(irq));
		wr(`WDR_ADDR_EVENT, 32'h2);
		@(posedge pclk);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(`WDR_ADDR_EVENT, 32'h0, "event cleared");
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, q);
		wr(`WDR_ADDR_MASK, 32'h7);
		// period between two pulses, for every select code
		for (int s = 0; s < 8; s++)
		begin
			wr(`WDR_ADDR_CTRL, 32'h8 | 32'(s));
			wait_pulse();
			wait_pulse();
			chk("period", 32'((4 << s) * 25), 32'(c));
			@(posedge pclk);
			chk("pulse width", 32'h0, 32'(pulse));
			chk("cause wd", 32'h1, 32'(reset_cause[3]));
		end
		chk("irq timeout", 32'h1, 32'(irq));
		wr(`WDR_ADDR_EVENT, 32'h7);
		wr(`WDR_ADDR_CTRL, 32'h08);
		hits = 0;
		repeat (10)
		begin
			repeat (60)
			begin
				@(posedge pclk);
				if (pulse === 1'b1)
					hits++;
			end
			kick <= 1'b1;
			@(posedge pclk);
			kick <= 1'b0;
		end
		chk("kicked pulses", 32'h0, 32'(hits));
		rd(`WDR_ADDR_EVENT, 32'h4, "event kick");
		summarize();
	end

	initial
	begin
		repeat (80000) @(posedge pclk);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
